/* File: logic/tsr_pkg.sv */
// Shared constants and types for the serial temperature readout block.
// Assumes a 50 MHz system clock and a master-driven serial clock on the link.
package tsr_pkg;

	// System clock rate and the cycles in one millisecond.
	localparam int unsigned TSR_CLK_HZ = 50000000;
	localparam int unsigned TSR_CYC_PER_MS = TSR_CLK_HZ / 1000;

	// Conversion and period times in milliseconds.
	localparam int unsigned TSR_CONV_TIME_MS = 250;
	localparam int unsigned TSR_CS_HOLD_MS = 300;
	localparam int unsigned TSR_PERIOD_FAST_MS = 500;
	localparam int unsigned TSR_PERIOD_SLOW_MS = 8000;

	// The same times as system clock cycles.
	localparam int unsigned TSR_CONV_CYC = TSR_CONV_TIME_MS * TSR_CYC_PER_MS;
	localparam int unsigned TSR_CS_HOLD_CYC = TSR_CS_HOLD_MS * TSR_CYC_PER_MS;
	localparam int unsigned TSR_PERIOD_FAST_CYC = TSR_PERIOD_FAST_MS * TSR_CYC_PER_MS;
	localparam int unsigned TSR_PERIOD_SLOW_CYC = TSR_PERIOD_SLOW_MS * TSR_CYC_PER_MS;

	// Word layout and field positions.
	localparam int unsigned TSR_WORD_W = 16;
	localparam int unsigned TSR_TEMP_W = 13;
	localparam int unsigned TSR_TIMER_W = 32;
	localparam int unsigned TSR_CNT_W = 5;
	localparam int unsigned TSR_TEMP_LSB = 3;
	localparam logic [2:0] TSR_TRAIL_BITS = 3'h0;
	localparam logic [TSR_TEMP_W-1:0] TSR_TEMP_POR = 13'h0000;

	// Bit counter landmarks on the link.
	localparam logic [TSR_CNT_W-1:0] TSR_CNT_CONFIRM = 5'h0d;
	localparam logic [TSR_CNT_W-1:0] TSR_CNT_HIZ = 5'h0e;
	localparam logic [TSR_CNT_W-1:0] TSR_CNT_DONE = 5'h10;

	typedef enum logic [1:0] {
		TSR_CONVERT,
		TSR_WAIT,
		TSR_IDLE
	} tsr_conv_e;

	typedef struct packed {
		tsr_conv_e state;
		logic [TSR_TIMER_W-1:0] timer;
		logic [TSR_TEMP_W-1:0] result;
		logic cs_prev;
		logic busy;
	} tsr_sys_s;

	typedef struct packed {
		logic [TSR_CNT_W-1:0] cnt;
	} tsr_link_s;

	typedef struct packed {
		logic ff1;
		logic ff2;
	} tsr_sync_s;

endpackage : tsr_pkg

/* File: logic/tsr_sync2.sv */
// Two-stage level synchroniser into the system clock domain.
// Assumes the input is an asynchronous level from a pin.
`timescale 1ns/1ps
module tsr_sync2
	import tsr_pkg::*;
#(
	parameter bit RST_VAL = 1'b0
)
(
	// Clock and reset.
	input wire logic sys_clk_in,
	input wire logic rst_b_in,
	// Level in and out.
	input wire logic level_in,
	output logic level_out
);

	tsr_sync_s q_q;
	tsr_sync_s q_d;

	always_comb
	begin
		q_d = q_q;
		q_d.ff1 = level_in;
		q_d.ff2 = q_q.ff1;
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			q_q <= '{ff1: RST_VAL, ff2: RST_VAL};
		end
		else
		begin
			q_q <= q_d;
		end
	end

	assign level_out = q_q.ff2;

endmodule : tsr_sync2

/* File: logic/tsr_link.sv */
// Link-side shifter running on the serial clock's falling edge.
// Assumes the reset is held while chip select is high and the word is stable in a frame.
`timescale 1ns/1ps
module tsr_link
	import tsr_pkg::*;
(
	// Link clock and frame reset.
	input wire logic sck_clk_in,
	input wire logic arst_b_in,
	// Word to shift out.
	input wire logic [TSR_WORD_W-1:0] word_in,
	// Serial output pin.
	output logic so_out,
	output logic so_oe_b_out
);

	tsr_link_s q_q;
	tsr_link_s q_d;

	function automatic logic [3:0] bit_of(input logic [TSR_CNT_W-1:0] cnt);
		bit_of = 4'hf - cnt[3:0];
	endfunction : bit_of

	always_comb
	begin
		q_d = q_q;
		if (q_q.cnt != TSR_CNT_DONE)
		begin
			q_d.cnt = q_q.cnt + 5'h01; // RULE6 RULE13 RULE18
		end
	end

	always_ff @(negedge sck_clk_in or negedge arst_b_in)
	begin
		if (!arst_b_in)
		begin
			q_q <= '{cnt: 5'h00}; // RULE3
		end
		else
		begin
			q_q <= q_d;
		end
	end

	// The pin follows the frame reset at once, so it floats whenever the frame is closed.
	assign so_out = word_in[bit_of(q_q.cnt)]; // RULE6 RULE9 RULE10
	assign so_oe_b_out = !arst_b_in || (q_q.cnt >= TSR_CNT_HIZ); // RULE11 RULE17

	property p_count;
		@(negedge sck_clk_in) disable iff (!arst_b_in)
		(q_q.cnt != 5'h00 && q_q.cnt != TSR_CNT_DONE) |-> (q_q.cnt == 5'($past(q_q.cnt) + 5'h01));
	endproperty

	AST_COUNT: assert property (p_count) else $error("bit counter did not advance"); // RULE6

	AST_CONFIRM: assert property (@(negedge sck_clk_in) disable iff (!arst_b_in) // RULE10
		(q_q.cnt == TSR_CNT_CONFIRM) |-> (!so_out && !so_oe_b_out))
		else $error("confirmation bit not driven low");

	AST_HIZ_TAIL: assert property (@(negedge sck_clk_in) disable iff (!arst_b_in) // RULE11
		(q_q.cnt >= TSR_CNT_HIZ) |-> so_oe_b_out)
		else $error("trailing bits not released");

	AST_SATURATE: assert property (@(negedge sck_clk_in) disable iff (!arst_b_in) // RULE18
		($past(q_q.cnt) == TSR_CNT_DONE && q_q.cnt != 5'h00) |-> (q_q.cnt == TSR_CNT_DONE))
		else $error("counter moved past the last bit");

	AST_DATA_BITS: assert property (@(negedge sck_clk_in) disable iff (!arst_b_in) // RULE13
		(q_q.cnt < TSR_CNT_CONFIRM) |-> (!so_oe_b_out && so_out == word_in[4'hf - q_q.cnt[3:0]]))
		else $error("data bit not driven in order");

endmodule : tsr_link

/* File: logic/tsr_top.sv */
// Top of the serial temperature readout: conversion sequencer and serial port.
// Assumes temp_in is a settled converter result on the system clock and that
// the master drives chip select and the serial clock as an SPI master.
`timescale 1ns/1ps

// Functional notes
// RULE1: Convert repeatedly while chip select is high.
// RULE2: Chip select low aborts conversion, enters idle.
// RULE3: Chip select rise restarts conversion, resets interface.
// RULE4: Master holds chip select high 300 ms.
// RULE5: Chip select fall freezes result for shifting.
// RULE6: Shift on serial clock fall, sign first.
// RULE7: Master reads all sixteen bits per frame.
// RULE8: Early abort needs a conversion time wait.
// RULE9: Bits fifteen to three carry temperature.
// RULE10: Bit two is always driven low.
// RULE11: Bits one and zero stay high-impedance.
// RULE12: Output floats after power until read.
// RULE13: Idle mode still shifts the latched result.
// RULE14: Reset holds interface off, result zero.
// RULE15: Reset release starts a conversion.
// RULE16: Period is eight or half second.
// RULE17: Output released whenever chip select is high.
// RULE18: Stray clocks never disturb result or conversion.
module tsr_top
	import tsr_pkg::*;
#(
	parameter bit LOW_POWER = 1'b0,
	parameter int unsigned CONV_CYC = TSR_CONV_CYC,
	parameter int unsigned PERIOD_CYC = LOW_POWER ? TSR_PERIOD_SLOW_CYC : TSR_PERIOD_FAST_CYC
)
(
	// System clock and power-on reset.
	input wire logic sys_clk_in,
	input wire logic rst_b_in,
	// Serial link from the master.
	input wire logic sck_clk_in,
	input wire logic cs_b_in,
	// Serial data pin.
	output logic so_out,
	output logic so_oe_b_out,
	// Converter result and status.
	input wire logic [TSR_TEMP_W-1:0] temp_in,
	output logic conv_busy_out
);

	// The conversion must take at least one cycle and finish inside the period.
	if (CONV_CYC < 1 || PERIOD_CYC <= CONV_CYC)
	begin : g_chk_cycles
		$error("tsr_top: CONV_CYC must be at least one and below PERIOD_CYC");
	end

	localparam logic [TSR_TIMER_W-1:0] CONV_LAST = TSR_TIMER_W'(CONV_CYC - 1);
	localparam logic [TSR_TIMER_W-1:0] PERIOD_LAST = TSR_TIMER_W'(PERIOD_CYC - 1);

	tsr_sys_s q_q;
	tsr_sys_s q_d;
	logic cs_hi_s;
	logic link_rst_b;
	logic [TSR_WORD_W-1:0] word;

	// Chip select reaches the sequencer only through two flip-flops.
	tsr_sync2 #(
		.RST_VAL(1'b1)
	) u_cs_sync (
		.sys_clk_in(sys_clk_in),
		.rst_b_in(rst_b_in),
		.level_in(cs_b_in),
		.level_out(cs_hi_s)
	);

	always_comb
	begin
		q_d = q_q;
		q_d.cs_prev = cs_hi_s;
		case (q_q.state)
			TSR_CONVERT:
			begin
				if (!cs_hi_s)
				begin
					q_d.state = TSR_IDLE; // RULE2
				end
				else if (q_q.timer == CONV_LAST)
				begin
					q_d.result = temp_in; // RULE9
					q_d.state = TSR_WAIT;
					q_d.timer = q_q.timer + 32'h0000_0001;
				end
				else
				begin
					q_d.timer = q_q.timer + 32'h0000_0001;
				end
			end
			TSR_WAIT:
			begin
				if (!cs_hi_s)
				begin
					q_d.state = TSR_IDLE; // RULE2
				end
				else if (q_q.timer == PERIOD_LAST)
				begin
					q_d.state = TSR_CONVERT; // RULE1 RULE16
					q_d.timer = 32'h0000_0000;
				end
				else
				begin
					q_d.timer = q_q.timer + 32'h0000_0001;
				end
			end
			TSR_IDLE:
			begin
				q_d.timer = 32'h0000_0000; // RULE5
			end
			default:
			begin
				q_d.state = TSR_IDLE;
				q_d.timer = 32'h0000_0000;
			end
		endcase
		if (cs_hi_s && !q_q.cs_prev)
		begin
			q_d.state = TSR_CONVERT; // RULE3
			q_d.timer = 32'h0000_0000;
		end
		q_d.busy = (q_d.state == TSR_CONVERT);
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			q_q <= '{state: TSR_CONVERT, timer: 32'h0000_0000, result: TSR_TEMP_POR, // RULE14 RULE15
				cs_prev: 1'b1, busy: 1'b1};
		end
		else
		begin
			q_q <= q_d;
		end
	end

	assign conv_busy_out = q_q.busy;

	// The result only changes at a conversion end, which can still fall in the first two system clocks
	// of a frame while chip select passes the synchroniser; after that the word stays still while the link reads it.
	assign word = {q_q.result, TSR_TRAIL_BITS}; // RULE5 RULE9 RULE10

	// The link is held at its start while chip select is high or power-on reset is active.
	assign link_rst_b = rst_b_in && !cs_b_in; // RULE3 RULE12 RULE14 RULE17 RULE18

	tsr_link u_link (
		.sck_clk_in(sck_clk_in),
		.arst_b_in(link_rst_b),
		.word_in(word),
		.so_out(so_out),
		.so_oe_b_out(so_oe_b_out)
	);

	sequence s_cs_rise;
		cs_hi_s && !q_q.cs_prev;
	endsequence

	sequence s_period_end;
		q_q.state == TSR_WAIT && q_q.timer == PERIOD_LAST && cs_hi_s && q_q.cs_prev;
	endsequence

	sequence s_conv_end;
		q_q.state == TSR_CONVERT && q_q.timer == CONV_LAST && cs_hi_s && q_q.cs_prev;
	endsequence

	property p_free_run;
		@(posedge sys_clk_in) disable iff (!rst_b_in)
		s_period_end |=> (q_q.state == TSR_CONVERT && q_q.timer == 32'h0000_0000 && conv_busy_out);
	endproperty

	property p_restart;
		@(posedge sys_clk_in) disable iff (!rst_b_in)
		s_cs_rise |=> (q_q.state == TSR_CONVERT && q_q.timer == 32'h0000_0000);
	endproperty

	property p_latch;
		@(posedge sys_clk_in) disable iff (!rst_b_in)
		s_conv_end |=> (q_q.result == $past(temp_in) && q_q.state == TSR_WAIT && !conv_busy_out);
	endproperty

	AST_FREE_RUN: assert property (p_free_run) else $error("conversion did not restart at period end"); // RULE1

	AST_ABORT: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // RULE2
		!cs_hi_s |=> (q_q.state == TSR_IDLE && !conv_busy_out))
		else $error("chip select low did not enter idle");

	AST_RESTART: assert property (p_restart) else $error("chip select rise did not restart"); // RULE3

	AST_FREEZE: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // RULE5
		(q_q.state == TSR_IDLE) |=> $stable(q_q.result))
		else $error("result changed while idle");

	AST_LATCH: assert property (p_latch) else $error("result not taken at conversion end"); // RULE9

	AST_RELEASE: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // RULE17
		cs_b_in |-> so_oe_b_out)
		else $error("output driven with chip select high");

	AST_POR: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // RULE14
		$rose(rst_b_in) |-> (q_q.result == TSR_TEMP_POR && q_q.state == TSR_CONVERT))
		else $error("reset state not zero result and converting");

	AST_PERIOD: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // RULE16
		(q_q.timer <= PERIOD_LAST) && (q_q.state != TSR_CONVERT || q_q.timer <= CONV_LAST))
		else $error("timer ran past its period");

endmodule : tsr_top

/* File: verif/tsr_master.sv */
// Serial master model that reads frames from the readout block.
// Assumes the bench calls its tasks and resolves the data line.
`timescale 1ns/1ps
module tsr_master
	import tsr_pkg::*;
(
	// Link towards the device.
	output logic sck_out,
	output logic cs_b_out,
	// Resolved data line and its enable.
	input wire logic so_in,
	input wire logic so_oe_b_in
);
	initial
	begin
		sck_out = 1'b0;
		cs_b_out = 1'b1;
	end

	task automatic set_cs(input logic lvl);
		#7 cs_b_out = lvl;
	endtask : set_cs

	// Clock n bits at a 12 ns period; the clock stands still between calls.
	task automatic shift(input int n, output logic [15:0] dat, output logic [15:0] hiz);
		dat = 16'h0000;
		hiz = 16'h0000;
		for (int i = 0; i < n; i++)
		begin
			#6 sck_out = 1'b1;
			if (i < 16)
			begin
				dat[15-i] = so_in;
				hiz[15-i] = so_oe_b_in;
			end
			#6 sck_out = 1'b0;
		end
	endtask : shift
endmodule : tsr_master

/* File: verif/tb_tsr_top.sv */
// Self-checking bench for the serial temperature readout.
// Assumes shortened conversion and period counts.
`timescale 1ns/1ps
module tb_tsr_top
	import tsr_pkg::*;
	;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [TSR_TEMP_W-1:0] temp;
	logic [TSR_TEMP_W-1:0] t;
	logic sck, cs_b, so, so_oe_b, busy;
	logic so_line;
	logic [15:0] dat, hiz;
	int mismatches = 0;
	int compares = 0;
	int cycles = 0;
	int seed = 32'h2154_3f2f;
	logic [TSR_TEMP_W-1:0] corner [4] = '{13'h0190, 13'h1fff, 13'h1000, 13'h0fff};

	assign so_line = so_oe_b ? ~so : so;

	tsr_top #(.CONV_CYC(20), .PERIOD_CYC(40)) dut (.sys_clk_in(sys_clk), .rst_b_in(rst_b),
		.sck_clk_in(sck), .cs_b_in(cs_b), .so_out(so), .so_oe_b_out(so_oe_b), .temp_in(temp),
		.conv_busy_out(busy));

	tsr_master master (.sck_out(sck), .cs_b_out(cs_b), .so_in(so_line), .so_oe_b_in(so_oe_b));

	always #10 sys_clk = ~sys_clk;

	task automatic miss(input string msg);
		mismatches++;
		$display("unexpected at %0t: %s", $time, msg);
	endtask : miss

	task automatic chk_bit(input logic got, input logic exp, input string msg);
		compares++;
		if (got !== exp)
			miss(msg);
	endtask : chk_bit

	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string msg);
		compares++;
		if (got !== exp)
			miss(msg);
	endtask : chk_word

	// Sign and temperature in the top thirteen bits, then the low confirmation bit.
	function automatic logic [15:0] exp_word(input logic [TSR_TEMP_W-1:0] tv);
		exp_word = {tv, 3'b000};
	endfunction : exp_word

	// Open a frame, idle with a changing converter value, then read and close.
	task automatic read_check(input logic [TSR_TEMP_W-1:0] exp, input int extra);
		master.set_cs(1'b0);
		repeat (2) @(posedge sys_clk);
		temp <= TSR_TEMP_W'($random(seed));
		repeat (60) @(posedge sys_clk);
		master.shift(16 + extra, dat, hiz);
		chk_word({dat[15:2], 2'b00}, exp_word(exp), "data bits");
		chk_word(hiz, 16'h0003, "output enable per bit");
		master.set_cs(1'b1);
		#1 chk_bit(so_oe_b, 1'b1, "released after frame");
		$display("test read %h done", exp);
	endtask : read_check

	// Hold power-on reset for three cycles, then read the cleared result.
	task automatic pulse_reset();
		rst_b <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1 chk_bit(so_oe_b, 1'b1, "pin floats in reset");
		chk_bit(busy, 1'b1, "busy in reset");
		@(posedge sys_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge sys_clk);
		#1 chk_bit(busy, 1'b1, "converting after reset");
		read_check(13'h0000, 0);
	endtask : pulse_reset

	task automatic finish_test();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test

	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			miss("run too long");
			finish_test();
		end
	end

	initial
	begin
		temp <= TSR_TEMP_W'($random(seed));
		pulse_reset();
		for (int k = 0; k < 10; k++)
		begin
			t = (k < 4) ? corner[k] : TSR_TEMP_W'($random(seed));
			@(posedge sys_clk);
			temp <= t;
			master.shift(3, dat, hiz);
			repeat (30) @(posedge sys_clk);
			#1 chk_bit(busy, 1'b0, "conversion done");
			repeat (20) @(posedge sys_clk);
			#1 chk_bit(busy, 1'b1, "next conversion runs");
			read_check(t, k % 4);
		end
		@(posedge sys_clk);
		pulse_reset();
		repeat (30) @(posedge sys_clk);
		master.set_cs(1'b0);
		master.shift(5, dat, hiz);
		master.set_cs(1'b1);
		#1 chk_bit(so_oe_b, 1'b1, "released on early rise");
		@(posedge sys_clk);
		t = 13'h1c90;
		temp <= t;
		repeat (30) @(posedge sys_clk);
		read_check(t, 0);
		finish_test();
	end
endmodule : tb_tsr_top
